// File: hw/gpb_port.sv
/*
 Sixteen-pin general-purpose I/O port with per-pin mode selection by three
 configuration bits and one data bit, alternate-function routing for the
 shared pins of port 0 and a wakeup input pin.
 Assumes a simple register strobe bus on the same clock, pins asynchronous,
 and peripherals on the same clock driving the alternate-function signals.
*/
`include "gpb_defines.svh"

// Contract
// - Code 001 gives floating TTL input; reads pin, writes ignored.
// - Code 010 gives floating CMOS input; reads pin, writes ignored.
// - Code 011 with data 0 gives CMOS input with pull-down.
// - Code 011 with data 1 gives CMOS input with pull-up.
// - Code 000 is analog input; digital input off, reads zero.
// - Code 100 is open-drain output from data; reads pin level.
// - Code 101 is push-pull output; reads the last written value.
// - Code 110 is alternate open-drain; reads pin, writes ignored.
// - Code 111 is alternate push-pull; reads pin, writes ignored.
// - Reset sets low=1, mid=1, high=0 on every pin: pulled input.
// - Data reset value per pin picks pull-up or pull-down.
// - Pins 0 and 1 alternate serve UART unless SPI enable is set.
// - In alternate modes the half-duplex UART pin is high impedance except while transmitting.
// - Pin 15 is input only, also wakeup; driver never enabled.
module gpb_port
  import gpb_pkg::*;
#(
  parameter int PINS = 16,
  parameter logic [PINS-1:0] DATA_RST = `GPB_PIN_VALUE_RST
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`GPB_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pull_up,
  output logic [PINS-1:0] pull_down,
  output logic [PINS-1:0] ttl_sel,
  output logic [PINS-1:0] analog_en,
  input wire logic spi_enable,
  input wire logic [3:0] spi_out,
  input wire logic [3:0] spi_oe,
  input wire logic [1:0] uart_out,
  input wire logic [1:0] uart_oe,
  input wire logic [1:0] i2c_out,
  input wire logic [1:0] i2c_oe,
  input wire logic [PINS-1:0] periph_out,
  input wire logic [PINS-1:0] periph_oe,
  input wire logic half_duplex_tx_busy,
  output logic [PINS-1:0] pin_level,
  output logic wakeup
);
  logic [PINS-1:0] cfg_low_r;
  logic [PINS-1:0] cfg_low_nxt;
  logic [PINS-1:0] cfg_mid_r;
  logic [PINS-1:0] cfg_mid_nxt;
  logic [PINS-1:0] cfg_high_r;
  logic [PINS-1:0] cfg_high_nxt;
  logic [PINS-1:0] data_r;
  logic [PINS-1:0] data_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [PINS-1:0] pad_out_r;
  logic [PINS-1:0] pad_out_nxt;
  logic [PINS-1:0] pad_oe_r;
  logic [PINS-1:0] pad_oe_nxt;
  logic [PINS-1:0] pu_r;
  logic [PINS-1:0] pu_nxt;
  logic [PINS-1:0] pd_r;
  logic [PINS-1:0] pd_nxt;
  logic [PINS-1:0] ttl_r;
  logic [PINS-1:0] ttl_nxt;
  logic [PINS-1:0] ana_r;
  logic [PINS-1:0] ana_nxt;
  logic [PINS-1:0] level_r;
  logic [PINS-1:0] level_nxt;
  logic wake_r;
  logic wake_nxt;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] alt_out;
  logic [PINS-1:0] alt_oe;
  logic [PINS-1:0] c_out;
  logic [PINS-1:0] c_oe;
  logic [PINS-1:0] c_pu;
  logic [PINS-1:0] c_pd;
  logic [PINS-1:0] c_ttl;
  logic [PINS-1:0] c_din;
  logic [PINS-1:0] data_view;

  gpb_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );

  // Alternate-function source selection for shared pins
  always_comb begin
    alt_out = periph_out;
    alt_oe = periph_oe;
    if (spi_enable) begin
      alt_out[3:0] = spi_out;
      alt_oe[3:0] = spi_oe;
    end else begin
      alt_out[`GPB_UART_PIN0] = uart_out[0];
      alt_oe[`GPB_UART_PIN0] = uart_oe[0];
      alt_out[`GPB_UART_PIN1] = uart_out[1];
      alt_oe[`GPB_UART_PIN1] = uart_oe[1];
      alt_out[`GPB_I2C_PIN0] = i2c_out[0];
      alt_oe[`GPB_I2C_PIN0] = i2c_oe[0];
      alt_out[`GPB_I2C_PIN1] = i2c_out[1];
      alt_oe[`GPB_I2C_PIN1] = i2c_oe[1];
    end
    alt_oe[`GPB_HALF_DUPLEX_PIN] = periph_oe[`GPB_HALF_DUPLEX_PIN] &&
                                   half_duplex_tx_busy;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      gpb_pin_ctl u_ctl (
        .mode(gpb_decode(cfg_high_r[gi], cfg_mid_r[gi], cfg_low_r[gi])),
        .data_bit(data_r[gi]),
        .alt_out(alt_out[gi]),
        .alt_oe(alt_oe[gi]),
        .input_only(gi == `GPB_WAKE_PIN),
        .pad_out(c_out[gi]),
        .pad_oe(c_oe[gi]),
        .pull_up(c_pu[gi]),
        .pull_down(c_pd[gi]),
        .ttl_sel(c_ttl[gi]),
        .dig_in_en(c_din[gi])
      );
      // Data read view per pin mode
      always_comb begin
        case (gpb_decode(cfg_high_r[gi], cfg_mid_r[gi], cfg_low_r[gi]))
          GPB_ANALOG: data_view[gi] = 1'b0;
          GPB_OUT_PP: data_view[gi] = data_r[gi];
          default: data_view[gi] = pin_sync[gi];
        endcase
      end
    end
  endgenerate

  // Register writes
  always_comb begin
    cfg_low_nxt = cfg_low_r;
    cfg_mid_nxt = cfg_mid_r;
    cfg_high_nxt = cfg_high_r;
    data_nxt = data_r;
    if (reg_wr) begin
      case (reg_addr)
        `GPB_OFS_CFG_LOW: cfg_low_nxt = reg_wdata[PINS-1:0];
        `GPB_OFS_CFG_MID: cfg_mid_nxt = reg_wdata[PINS-1:0];
        `GPB_OFS_CFG_HIGH: cfg_high_nxt = reg_wdata[PINS-1:0];
        `GPB_OFS_PIN_VALUE: data_nxt = reg_wdata[PINS-1:0];
        default: data_nxt = data_r;
      endcase
    end
  end

  // Register reads, one cycle later; zero elsewhere
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `GPB_OFS_CFG_LOW: rdata_nxt[PINS-1:0] = cfg_low_r;
        `GPB_OFS_CFG_MID: rdata_nxt[PINS-1:0] = cfg_mid_r;
        `GPB_OFS_CFG_HIGH: rdata_nxt[PINS-1:0] = cfg_high_r;
        `GPB_OFS_PIN_VALUE: rdata_nxt[PINS-1:0] = data_view;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Pin-facing outputs, registered
  always_comb begin
    pad_out_nxt = c_out;
    pad_oe_nxt = c_oe;
    pu_nxt = c_pu;
    pd_nxt = c_pd;
    ttl_nxt = c_ttl;
    ana_nxt = ~c_din;
    level_nxt = pin_sync & c_din;
    wake_nxt = pin_sync[`GPB_WAKE_PIN];
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cfg_low_r <= `GPB_CFG_LOW_RST;
      cfg_mid_r <= `GPB_CFG_MID_RST;
      cfg_high_r <= `GPB_CFG_HIGH_RST;
      data_r <= DATA_RST;
      rdata_r <= 32'h0000_0000;
      pad_out_r <= '0;
      pad_oe_r <= '0;
      pu_r <= DATA_RST;
      pd_r <= ~DATA_RST;
      ttl_r <= '0;
      ana_r <= '0;
      level_r <= '0;
      wake_r <= 1'b0;
    end else begin
      cfg_low_r <= cfg_low_nxt;
      cfg_mid_r <= cfg_mid_nxt;
      cfg_high_r <= cfg_high_nxt;
      data_r <= data_nxt;
      rdata_r <= rdata_nxt;
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
      ttl_r <= ttl_nxt;
      ana_r <= ana_nxt;
      level_r <= level_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign pull_up = pu_r;
  assign pull_down = pd_r;
  assign ttl_sel = ttl_r;
  assign analog_en = ana_r;
  assign pin_level = level_r;
  assign wakeup = wake_r;
endmodule : gpb_port

// File: hw/gpb_defines.svh
/*
 Offsets, field positions and reset values of the GPIO port.
 Assumes inclusion by bare name from the design files.
*/
`ifndef GPB_DEFINES_SVH
`define GPB_DEFINES_SVH
`define GPB_ADDR_W 4
`define GPB_OFS_CFG_LOW 4'h0
`define GPB_OFS_CFG_MID 4'h4
`define GPB_OFS_CFG_HIGH 4'h8
`define GPB_OFS_PIN_VALUE 4'hc
`define GPB_CFG_LOW_RST 16'hffff
`define GPB_CFG_MID_RST 16'hffff
`define GPB_CFG_HIGH_RST 16'h0000
`define GPB_PIN_VALUE_RST 16'h607f
`define GPB_WAKE_PIN 15
`define GPB_SPI_EN_BIT 0
`define GPB_UART_PIN0 0
`define GPB_UART_PIN1 1
`define GPB_I2C_PIN0 2
`define GPB_I2C_PIN1 3
`define GPB_HALF_DUPLEX_PIN 8
`endif

// File: hw/gpb_pkg.sv
/*
 Types of the GPIO port: the pin mode decoded from three configuration bits.
 Assumes nothing of its surroundings.
*/
package gpb_pkg;
  typedef enum logic [2:0] {
    GPB_ANALOG,
    GPB_IN_TTL,
    GPB_IN_CMOS,
    GPB_IN_PULL,
    GPB_OUT_OD,
    GPB_OUT_PP,
    GPB_ALT_OD,
    GPB_ALT_PP
  } gpb_mode_t;

  function automatic gpb_mode_t gpb_decode(input logic hi, input logic mid,
                                           input logic lo);
    case ({hi, mid, lo})
      3'h0: gpb_decode = GPB_ANALOG;
      3'h1: gpb_decode = GPB_IN_TTL;
      3'h2: gpb_decode = GPB_IN_CMOS;
      3'h3: gpb_decode = GPB_IN_PULL;
      3'h4: gpb_decode = GPB_OUT_OD;
      3'h5: gpb_decode = GPB_OUT_PP;
      3'h6: gpb_decode = GPB_ALT_OD;
      default: gpb_decode = GPB_ALT_PP;
    endcase
  endfunction : gpb_decode
endpackage : gpb_pkg

// File: hw/gpb_sync.sv
/*
 Two flip-flop synchroniser for the pin inputs.
 Assumes asynchronous pin levels and one clock.
*/
module gpb_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : gpb_sync

// File: hw/gpb_pin_ctl.sv
/*
 Per-pin driver control: output value, output enable, pull controls and
 digital input enable for one pin, from its mode and data bit.
 Assumes the alternate-function source is already selected by the caller.
*/
module gpb_pin_ctl
  import gpb_pkg::*;
(
  input wire gpb_mode_t mode,
  input wire logic data_bit,
  input wire logic alt_out,
  input wire logic alt_oe,
  input wire logic input_only,
  output logic pad_out,
  output logic pad_oe,
  output logic pull_up,
  output logic pull_down,
  output logic ttl_sel,
  output logic dig_in_en
);
  logic drv_out;
  logic drv_oe;

  always_comb begin
    drv_out = 1'b0;
    drv_oe = 1'b0;
    pull_up = 1'b0;
    pull_down = 1'b0;
    ttl_sel = 1'b0;
    dig_in_en = 1'b1;
    case (mode)
      GPB_ANALOG: dig_in_en = 1'b0;
      GPB_IN_TTL: ttl_sel = 1'b1;
      GPB_IN_CMOS: ttl_sel = 1'b0;
      GPB_IN_PULL: begin
        pull_up = data_bit;
        pull_down = !data_bit;
      end
      GPB_OUT_OD: begin
        drv_out = 1'b0;
        drv_oe = !data_bit;
      end
      GPB_OUT_PP: begin
        drv_out = data_bit;
        drv_oe = 1'b1;
      end
      GPB_ALT_OD: begin
        drv_out = 1'b0;
        drv_oe = alt_oe && !alt_out;
      end
      GPB_ALT_PP: begin
        drv_out = alt_out;
        drv_oe = alt_oe;
      end
      default: begin
        drv_out = 1'b0;
        drv_oe = 1'b0;
      end
    endcase
    pad_out = drv_out;
    pad_oe = drv_oe && !input_only;
  end
endmodule : gpb_pin_ctl

// File: tb/gpb_port_props.sv
/* Checker of the port outputs against their causes.
   Assumes binding to gpb_port, one clock, sync reset. */
module gpb_port_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] pad_in,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pull_up,
  input wire logic [15:0] pull_down,
  input wire logic [15:0] ttl_sel,
  input wire logic [15:0] analog_en,
  input wire logic wakeup
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [1:0] age_r;
  logic [1:0] age_nxt;
  // Edges since reset release, saturating
  always_comb age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
  always_ff @(posedge clock) age_r <= rst_b ? age_nxt : 2'h0;

  wake_follows_a: assert property (
    age_r == 2'h3 |-> wakeup == $past(pad_in[15], 3))
    else $error("wakeup does not follow pin 15");
  wake_undriven_a: assert property (!pad_oe[15])
    else $error("pin 15 driven");
  pull_excl_a: assert property ((pull_up & pull_down) == 16'h0)
    else $error("pull-up and pull-down together");
  pull_input_a: assert property (
    ((pull_up | pull_down) & pad_oe) == 16'h0)
    else $error("pull on a driven pin");
  ttl_floating_a: assert property (
    (ttl_sel & (pull_up | pull_down | pad_oe | analog_en)) == 16'h0)
    else $error("ttl pin not floating");
  analog_off_a: assert property (
    (analog_en & (pad_oe | pull_up | pull_down)) == 16'h0)
    else $error("analog pin has digital driver");
  rdata_upper_a: assert property (reg_rdata[31:16] == 16'h0)
    else $error("read data upper half set");
  reset_pulls_a: assert property (
    $rose(rst_b) |-> pull_up == 16'h607f && pull_down == 16'h9f80
      && pad_oe == 16'h0)
    else $error("pins not pulled after reset");
  pull_by_write_a: assert property (
    $changed(pull_up) |-> $past(reg_wr, 2))
    else $error("pull changed without a write");
  cover property (reg_rd);
  cover property (pad_oe != 16'h0);
  cover property ($rose(wakeup));
endmodule : gpb_port_props

bind gpb_port gpb_port_props u_props (.clock, .rst_b, .reg_wr, .reg_rd,
  .reg_rdata, .pad_in, .pad_oe, .pull_up, .pull_down, .ttl_sel,
  .analog_en, .wakeup);

// File: tb/gpb_pins.sv
/* Board side of the pins: port drivers, weak pulls, outside sources.
   Assumes one clock; an undriven unpulled pin toggles every cycle. */
module gpb_pins (
  input wire logic clock,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pull_up,
  input wire logic [15:0] pull_down,
  input wire logic [15:0] ext_drv,
  input wire logic [15:0] ext_val,
  output logic [15:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] flt_r = 16'h0;
  always @(posedge clock) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_drv[i]) pad_in[i] = ext_val[i];
      else if (pull_up[i] || pull_down[i]) pad_in[i] = pull_up[i];
      else pad_in[i] = flt_r[i];
    end
  end
endmodule : gpb_pins

// File: tb/gpb_port_bench.sv
/* Bench of the port: register tasks, mode table, alternate routing.
   Assumes gpb_port and the pin model gpb_pins. */
`include "gpb_defines.svh"
module gpb_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic spi_enable = 1'b0;
  logic busy = 1'b0;
  logic [3:0] spi_out = 4'h6;
  logic [3:0] spi_oe = 4'h5;
  logic [1:0] uart_out = 2'h1;
  logic [1:0] uart_oe = 2'h3;
  logic [1:0] i2c_out = 2'h2;
  logic [1:0] i2c_oe = 2'h3;
  logic [15:0] periph_out = 16'h0800;
  logic [15:0] periph_oe = 16'h0c00;
  logic [15:0] ext_drv = 16'h0;
  logic [15:0] ext_val = 16'h0;
  logic [31:0] reg_rdata;
  logic [15:0] pad_in, pad_out, pad_oe, pull_up, pull_down;
  logic [15:0] ttl_sel, analog_en, pin_level, w;
  logic wakeup;
  int miscompares = 0;
  int checks = 0;

  gpb_port u_dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pad_in, .pad_out, .pad_oe, .pull_up,
    .pull_down, .ttl_sel, .analog_en, .spi_enable, .spi_out, .spi_oe,
    .uart_out, .uart_oe, .i2c_out, .i2c_oe, .periph_out, .periph_oe,
    .half_duplex_tx_busy(busy), .pin_level, .wakeup);
  gpb_pins u_pins (.clock, .pad_out, .pad_oe, .pull_up, .pull_down,
    .ext_drv, .ext_val, .pad_in);

  initial forever #2.5 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {16'h0, d};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input string what);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(what, {16'h0, e}, reg_rdata);
  endtask : rd

  task automatic settle;
    repeat (6) @(posedge clock);
    #1;
  endtask : settle

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (2000) @(posedge clock);
    miscompares++;
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    settle;
    rd(`GPB_OFS_CFG_LOW, 16'hffff, "cfg_low");
    rd(`GPB_OFS_CFG_MID, 16'hffff, "cfg_mid");
    rd(`GPB_OFS_CFG_HIGH, 16'h0000, "cfg_high");
    rd(`GPB_OFS_PIN_VALUE, 16'h607f, "pulled pins");
    rd(4'h2, 16'h0000, "unmapped");
    // Pin 4+c gets mode code c, pin 15 push-pull
    wr(`GPB_OFS_CFG_LOW, 16'hfaaf);
    wr(`GPB_OFS_CFG_MID, 16'h7ccf);
    wr(`GPB_OFS_CFG_HIGH, 16'h8f00);
    rd(`GPB_OFS_CFG_MID, 16'h7ccf, "cfg_mid back");
    ext_drv <= 16'hffff;
    for (int k = 0; k < 2; k++) begin
      w = k ? 16'ha5a5 : 16'h5a5a;
      ext_val <= ~w | 16'h0100;
      wr(`GPB_OFS_PIN_VALUE, w);
      settle;
      rd(`GPB_OFS_PIN_VALUE, (ext_val & 16'h70ef) | (w & 16'h8300)
        | 16'h0800, "pin_value");
      chk("pull_up", {16'h0, w & 16'h708f}, {16'h0, pull_up});
      chk("pull_down", {16'h0, ~w & 16'h708f}, {16'h0, pull_down});
      chk("pad_oe", {16'h0, 16'h0e00 | (~w & 16'h0100)},
        {16'h0, pad_oe});
      chk("pad_out", {16'h0, (w & 16'h0200) | 16'h0800},
        {16'h0, pad_out & 16'h0a00});
      chk("ttl_sel", 32'h0020, {16'h0, ttl_sel});
      chk("analog_en", 32'h0010, {16'h0, analog_en});
      chk("wakeup", {31'h0, ext_val[15]}, {31'h0, wakeup});
      chk("pin_level", {16'h0, (ext_val & 16'hf0ef) | (w & 16'h0300)
        | 16'h0800}, {16'h0, pin_level});
    end
    // Pins 0-3 and 8 to alternate push-pull
    wr(`GPB_OFS_CFG_LOW, 16'hfbaf);
    wr(`GPB_OFS_CFG_MID, 16'h7dcf);
    wr(`GPB_OFS_CFG_HIGH, 16'h8f0f);
    periph_out <= 16'h0900;
    periph_oe <= 16'h0d00;
    for (int s = 0; s < 2; s++) begin
      spi_enable <= s[0];
      busy <= s[0];
      settle;
      chk("shared out", s ? 32'h6 : 32'h9, {28'h0, pad_out[3:0]});
      chk("shared oe", s ? 32'h5 : 32'hf, {28'h0, pad_oe[3:0]});
      chk("half duplex oe", s, {31'h0, pad_oe[8]});
    end
    report_and_stop;
  end
endmodule : gpb_port_bench
